// *** pkg/pin_mux_pkg.sv ***
// What this block does
// RQ1: Timer2 ch4 out on pin2 if unremapped, enabled, alternate
// RQ2: Timer2 ch4 input from pin2 when unremapped
// RQ3: Serial2 TWI clock open-drain on pin2 conditions
// RQ4: Serial2 SPI master clock on pin2 conditions
// RQ5: Serial2 SPI slave clock from pin2
// RQ6: Serial2 SPI slave select from pin3
// RQ7: CPU trace clock on pin3 conditions
// RQ8: Timer2 ch2 out on pin3 conditions
// RQ9: Timer2 ch2 input from pin3 when unremapped
// RQ10: Pin4 to analog input four when analog
// RQ11: Packet trace frame on pin4 without core trace
// RQ12: CPU trace data bit2 on pin4, 4-wire
// RQ13: Pin5 to analog input five when analog
// RQ14: Packet trace data on pin5 without core trace
// RQ15: Pin5 low at reset requests bootloader
// RQ16: CPU trace data bit3 on pin5, 4-wire
// RQ17: Timer1 ch3 out on pin6 when enabled, alternate
// RQ18: Timer1 ch3 input always from pin6
// RQ19: Otherwise pin is plain GPIO
package pin_mux_pkg;
  localparam int NPINS = 5;
  localparam int FIELD_W = 4;
  // Pin order in vectors: index 0..4 = port A bits 2..6
  localparam int P2 = 0;
  localparam int P3 = 1;
  localparam int P4 = 2;
  localparam int P5 = 3;
  localparam int P6 = 4;
  // Config field positions
  localparam int LOW_BIT2_LSB = 8;
  localparam int LOW_BIT3_LSB = 12;
  localparam int HIGH_BIT4_LSB = 0;
  localparam int HIGH_BIT5_LSB = 4;
  localparam int HIGH_BIT6_LSB = 8;
  // Remap bits, mode bits and timer output-enable bits
  localparam int REMAP_CH2_BIT = 5;
  localparam int REMAP_CH4_BIT = 7;
  localparam int SPI_MASTER_BIT = 4;
  localparam int CCER_CH2_BIT = 4;
  localparam int CCER_CH3_BIT = 8;
  localparam int CCER_CH4_BIT = 12;
  // Config field encodings (plain defaults)
  localparam logic [3:0] CFG_ANALOG = 4'h0;
  localparam logic [3:0] CFG_OUT = 4'h1;
  localparam logic [3:0] CFG_OUT_OD = 4'h5;
  localparam logic [3:0] CFG_INPUT = 4'h4;
  localparam logic [3:0] CFG_ALT_OUT = 4'h9;
  localparam logic [3:0] CFG_ALT_OD = 4'hD;
  localparam logic [1:0] SER_MODE_SPI = 2'h2;
  localparam logic [1:0] SER_MODE_TWI = 2'h3;

  typedef enum logic [1:0] {
    BOOT_IN_RESET = 2'b00,
    BOOT_SAMPLE   = 2'b01,
    BOOT_DONE     = 2'b10
  } boot_state_t;

  typedef struct packed {
    logic [31:0] low_cfg;
    logic [31:0] high_cfg;
    logic [7:0]  tim2_remap;
    logic [15:0] timer_two_output_enables;
    logic [15:0] timer_one_output_enables;
    logic [1:0]  ser2_mode;
    logic [7:0]  ser2_spicfg;
    logic        trace_en;
    logic        trace_4wire;
  } mux_cfg_t;

  typedef struct packed {
    logic timer_two_channel_four;
    logic timer_two_channel_two;
    logic timer_one_channel_three;
    logic ser2_twi_clk;
    logic ser2_spi_clk;
    logic trace_clk;
    logic trace_d2;
    logic trace_d3;
    logic pkt_frame;
    logic pkt_data;
  } periph_out_t;

  typedef struct packed {
    logic timer_two_channel_four;
    logic timer_two_channel_two;
    logic timer_one_channel_three;
    logic ser2_spi_clk;
    logic ser2_ssel_n;
  } periph_in_t;
endpackage

// *** rtl/pin_sync2.sv ***
module pin_sync2
  import pin_mux_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         i_clock,  // System clock
  input  wire logic         i_rst_n,  // Async reset
  input  wire logic [W-1:0] i_async,  // Raw pin levels
  output logic      [W-1:0] o_sync    // Synchronised levels
);
  logic [W-1:0] meta_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// *** rtl/boot_strap.sv ***
module boot_strap
  import pin_mux_pkg::*;
(
  input  wire logic i_clock,        // System clock
  input  wire logic i_rst_n,        // Async reset
  input  wire logic i_ext_reset_n,  // Synchronised external reset
  input  wire logic i_strap_n,      // Synchronised pin5 level
  output logic      o_boot_req      // Bootloader activation
);
  boot_state_t state_q, state_d;
  logic        boot_d;
  // Synchroniser holds reset zeros for two cycles; a zero there would fake a strap
  logic [1:0]  primed_q;

  // Sampled while external reset is low and on the cycle just after release
  assign state_d = !i_ext_reset_n           ? BOOT_IN_RESET :
                   (state_q == BOOT_IN_RESET) ? BOOT_SAMPLE : BOOT_DONE;
  assign boot_d  = (primed_q[1] && (state_q != BOOT_DONE)) ? !i_strap_n : o_boot_req; // RQ15

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q    <= BOOT_IN_RESET;
      primed_q   <= '0;
      o_boot_req <= 1'b0;
    end else begin
      state_q    <= state_d;
      primed_q   <= {primed_q[0], 1'b1};
      o_boot_req <= boot_d;
    end
  end
endmodule

// *** rtl/port_a_upper_pin_mux.sv ***
module port_a_upper_pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic             i_clock,              // 25 MHz system clock
  input  wire logic             i_rst_n,              // Async reset, active low
  input  wire logic             i_external_reset_n,   // External reset pin level
  input  wire mux_cfg_t         i_cfg,                // Register-side selections
  input  wire periph_out_t      i_periph,             // Peripheral outputs
  input  wire logic [NPINS-1:0] i_gpio_out,           // GPIO data out per pin
  input  wire logic [NPINS-1:0] i_gpio_oe,            // GPIO direction per pin
  input  wire logic [NPINS-1:0] i_pad_in,             // Pad input levels
  output logic      [NPINS-1:0] o_pad_out,            // Pad output level
  output logic      [NPINS-1:0] o_pad_oe,             // Pad output enable
  output logic      [NPINS-1:0] o_pad_analog,         // Pad switched to analog
  output logic      [NPINS-1:0] o_gpio_in,            // Synced pin levels to GPIO
  output periph_in_t            o_periph,             // Inputs to peripherals
  output logic                  o_analog_input_four,  // ADC channel 4 connected
  output logic                  o_analog_input_five,  // ADC channel 5 connected
  output logic                  o_bootloader_req      // Bootloader requested
);
  logic [NPINS-1:0] pin_s;
  logic             ext_rst_s;
  logic             boot_req;

  pin_sync2 #(.W(NPINS + 1)) u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_external_reset_n, i_pad_in}),
    .o_sync  ({ext_rst_s, pin_s})
  );

  boot_strap u_boot (
    .i_clock       (i_clock),
    .i_rst_n       (i_rst_n),
    .i_ext_reset_n (ext_rst_s),
    .i_strap_n     (pin_s[P5]),
    .o_boot_req    (boot_req)
  );

  // Per-pin config fields
  wire logic [FIELD_W-1:0] cfg2 = i_cfg.low_cfg[LOW_BIT2_LSB +: FIELD_W];
  wire logic [FIELD_W-1:0] cfg3 = i_cfg.low_cfg[LOW_BIT3_LSB +: FIELD_W];
  wire logic [FIELD_W-1:0] cfg4 = i_cfg.high_cfg[HIGH_BIT4_LSB +: FIELD_W];
  wire logic [FIELD_W-1:0] cfg5 = i_cfg.high_cfg[HIGH_BIT5_LSB +: FIELD_W];
  wire logic [FIELD_W-1:0] cfg6 = i_cfg.high_cfg[HIGH_BIT6_LSB +: FIELD_W];

  wire logic remap4   = i_cfg.tim2_remap[REMAP_CH4_BIT];
  wire logic remap2   = i_cfg.tim2_remap[REMAP_CH2_BIT];
  wire logic ch4_en   = i_cfg.timer_two_output_enables[CCER_CH4_BIT];
  wire logic ch2_en   = i_cfg.timer_two_output_enables[CCER_CH2_BIT];
  wire logic t1ch3_en = i_cfg.timer_one_output_enables[CCER_CH3_BIT];
  wire logic spi_mode = (i_cfg.ser2_mode == SER_MODE_SPI);
  wire logic twi_mode = (i_cfg.ser2_mode == SER_MODE_TWI);
  wire logic spi_mst  = i_cfg.ser2_spicfg[SPI_MASTER_BIT];
  wire logic trc      = i_cfg.trace_en;
  wire logic trc4     = i_cfg.trace_en && i_cfg.trace_4wire;

  wire logic alt2 = (cfg2 == CFG_ALT_OUT);
  wire logic od2  = (cfg2 == CFG_ALT_OD);
  wire logic alt3 = (cfg3 == CFG_ALT_OUT);
  wire logic alt4 = (cfg4 == CFG_ALT_OUT);
  wire logic alt5 = (cfg5 == CFG_ALT_OUT);
  wire logic alt6 = (cfg6 == CFG_ALT_OUT);
  wire logic ana4 = (cfg4 == CFG_ANALOG);
  wire logic ana5 = (cfg5 == CFG_ANALOG);

  // Timer has priority; serial/trace only when timer is off or remapped away
  wire logic t2c4_sel = !remap4 && ch4_en && alt2;                      // RQ1
  wire logic pin2_free = !ch4_en || remap4;
  wire logic twi_sel  = twi_mode && od2 && pin2_free;                   // RQ3
  wire logic sck_sel  = spi_mode && spi_mst && alt2 && pin2_free;       // RQ4
  wire logic t2c2_sel = !remap2 && ch2_en && alt3;                      // RQ8
  wire logic tclk_sel = trc && alt3 && (!ch2_en || remap2);             // RQ7
  wire logic td2_sel  = trc4 && alt4;                                   // RQ12
  wire logic ptf_sel  = !trc && alt4;                                   // RQ11
  wire logic td3_sel  = trc4 && alt5;                                   // RQ16
  wire logic ptd_sel  = !trc && alt5;                                   // RQ14
  wire logic t1c3_sel = t1ch3_en && alt6;                               // RQ17

  // Open drain: drive only the low level, release for high
  wire logic out2 = t2c4_sel ? i_periph.timer_two_channel_four :
                    twi_sel  ? 1'b0 :
                    sck_sel  ? i_periph.ser2_spi_clk : i_gpio_out[P2];
  wire logic oe2  = t2c4_sel || sck_sel ? 1'b1 :
                    twi_sel  ? !i_periph.ser2_twi_clk :
                    (alt2 || od2) ? 1'b0 : i_gpio_oe[P2];                // RQ19
  wire logic out3 = t2c2_sel ? i_periph.timer_two_channel_two :
                    tclk_sel ? i_periph.trace_clk : i_gpio_out[P3];
  wire logic oe3  = (t2c2_sel || tclk_sel) ? 1'b1 : alt3 ? 1'b0 : i_gpio_oe[P3];
  wire logic out4 = td2_sel ? i_periph.trace_d2 :
                    ptf_sel ? i_periph.pkt_frame : i_gpio_out[P4];
  wire logic oe4  = (td2_sel || ptf_sel) ? 1'b1 :
                    (alt4 || ana4) ? 1'b0 : i_gpio_oe[P4];
  wire logic out5 = td3_sel ? i_periph.trace_d3 :
                    ptd_sel ? i_periph.pkt_data : i_gpio_out[P5];
  wire logic oe5  = (td3_sel || ptd_sel) ? 1'b1 :
                    (alt5 || ana5) ? 1'b0 : i_gpio_oe[P5];
  wire logic out6 = t1c3_sel ? i_periph.timer_one_channel_three : i_gpio_out[P6];
  wire logic oe6  = t1c3_sel ? 1'b1 : alt6 ? 1'b0 : i_gpio_oe[P6];

  // Idle levels keep peripherals quiet when not routed
  periph_in_t pin_in_d;
  assign pin_in_d.timer_two_channel_four     = remap4 ? 1'b0 : pin_s[P2];             // RQ2
  assign pin_in_d.timer_two_channel_two     = remap2 ? 1'b0 : pin_s[P3];             // RQ9
  assign pin_in_d.timer_one_channel_three     = pin_s[P6];                             // RQ18
  assign pin_in_d.ser2_spi_clk = (spi_mode && !spi_mst) ? pin_s[P2] : 1'b0; // RQ5
  assign pin_in_d.ser2_ssel_n  = (spi_mode && !spi_mst) ? pin_s[P3] : 1'b1; // RQ6

  // Registered outputs add one cycle of latency on each path
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_out           <= '0;
      o_pad_oe            <= '0;
      o_pad_analog        <= '0;
      o_gpio_in           <= '0;
      o_periph            <= '{timer_two_channel_four: 1'b0, timer_two_channel_two: 1'b0, timer_one_channel_three: 1'b0,
                               ser2_spi_clk: 1'b0, ser2_ssel_n: 1'b1};
      o_analog_input_four <= 1'b0;
      o_analog_input_five <= 1'b0;
      o_bootloader_req    <= 1'b0;
    end else begin
      o_pad_out           <= {out6, out5, out4, out3, out2};
      o_pad_oe            <= {oe6, oe5, oe4, oe3, oe2};
      o_pad_analog        <= {1'b0, ana5, ana4, 2'b00};
      o_gpio_in           <= pin_s;
      o_periph            <= pin_in_d;
      o_analog_input_four <= ana4;                                      // RQ10
      o_analog_input_five <= ana5;                                      // RQ13
      o_bootloader_req    <= boot_req;                                  // RQ15
    end
  end
endmodule

// *** verif/pin_mux_properties.sv ***
module pin_mux_properties
  import pin_mux_pkg::*;
(
  input wire logic             i_clock,            // Clock
  input wire logic             i_rst_n,            // Reset
  input wire mux_cfg_t         i_cfg,              // Selections
  input wire periph_out_t      i_periph,           // Peripheral outputs
  input wire logic [NPINS-1:0] o_pad_out,          // Pad level
  input wire logic [NPINS-1:0] o_pad_oe,           // Pad enable
  input wire logic [NPINS-1:0] o_pad_analog,       // Analog switch
  input wire logic             o_analog_input_four // ADC four link
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_ch4_on;
    i_cfg.low_cfg[11:8] == CFG_ALT_OUT && i_cfg.timer_two_output_enables[12] && !i_cfg.tim2_remap[7];
  endsequence
  sequence s_ch4_off;
    !i_cfg.timer_two_output_enables[12] || i_cfg.tim2_remap[7];
  endsequence
  a_ch4_pin_drive: assert property (s_ch4_on |=> o_pad_oe[0] && o_pad_out[0] == $past(i_periph.timer_two_channel_four))
    else $error("timer channel four missing on pin2");
  a_twi_open_drain: assert property (i_cfg.ser2_mode == SER_MODE_TWI && i_cfg.low_cfg[11:8] == CFG_ALT_OD ##0
    s_ch4_off |=> !o_pad_out[0] && o_pad_oe[0] == !$past(i_periph.ser2_twi_clk))
    else $error("twi clock not open drain on pin2");
  a_spi_master_clk: assert property (i_cfg.ser2_mode == SER_MODE_SPI && i_cfg.ser2_spicfg[4]
    && i_cfg.low_cfg[11:8] == CFG_ALT_OUT ##0 s_ch4_off |=> o_pad_oe[0] && o_pad_out[0] == $past(i_periph.ser2_spi_clk))
    else $error("spi clock missing on pin2");
  a_trace_clk_drive: assert property (i_cfg.trace_en && i_cfg.low_cfg[15:12] == CFG_ALT_OUT
    && (!i_cfg.timer_two_output_enables[4] || i_cfg.tim2_remap[5]) |=> o_pad_oe[1] && o_pad_out[1] == $past(i_periph.trace_clk))
    else $error("trace clock missing on pin3");
  a_ch2_pin_drive: assert property (i_cfg.low_cfg[15:12] == CFG_ALT_OUT && i_cfg.timer_two_output_enables[4]
    && !i_cfg.tim2_remap[5] |=> o_pad_oe[1] && o_pad_out[1] == $past(i_periph.timer_two_channel_two))
    else $error("timer channel two missing on pin3");
  a_adc_link_follows: assert property (1'b1 |=> o_analog_input_four == $past(i_cfg.high_cfg[3:0] == CFG_ANALOG)
    && o_pad_analog[3] == $past(i_cfg.high_cfg[7:4] == CFG_ANALOG))
    else $error("analog switch wrong");
  a_pkt_frame_drive: assert property (!i_cfg.trace_en && i_cfg.high_cfg[3:0] == CFG_ALT_OUT
    |=> o_pad_oe[2] && o_pad_out[2] == $past(i_periph.pkt_frame))
    else $error("packet frame missing on pin4");
  a_ch3_pin_drive: assert property (i_cfg.high_cfg[11:8] == CFG_ALT_OUT && i_cfg.timer_one_output_enables[8]
    |=> o_pad_oe[4] && o_pad_out[4] == $past(i_periph.timer_one_channel_three))
    else $error("timer one channel three missing on pin6");
endmodule

// *** verif/board_pads.sv ***
module board_pads
  import pin_mux_pkg::*;
(
  input  wire logic [NPINS-1:0] i_pad_out, // Device drive level
  input  wire logic [NPINS-1:0] i_pad_oe,  // Device drives pin
  input  wire logic [NPINS-1:0] i_ext,     // Board level when released
  output logic      [NPINS-1:0] o_pin      // Wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pins show the board level, so a stale drive never looks valid
  assign o_pin = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext);
endmodule

// *** verif/tb_top.sv ***
module tb_top
  import pin_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             i_clock, i_rst_n, i_external_reset_n, an4, an5, boot;
  mux_cfg_t         cfg;
  periph_out_t      per;
  periph_in_t       pin_in;
  logic [NPINS-1:0] gpio_out, gpio_oe, ext, pin, pad_out, pad_oe, pad_analog, gpio_in;
  int               mismatches, n_checks;
  port_a_upper_pin_mux u_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_external_reset_n(i_external_reset_n), .i_cfg(cfg),
    .i_periph(per), .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe), .i_pad_in(pin), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .o_pad_analog(pad_analog), .o_gpio_in(gpio_in), .o_periph(pin_in),
    .o_analog_input_four(an4), .o_analog_input_five(an5), .o_bootloader_req(boot));
  board_pads u_pads (.i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_ext(ext), .o_pin(pin));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    i_rst_n = 1'b0;
    i_external_reset_n = 1'b1;
    cfg = '0;
    cfg.low_cfg = 32'h4444_4444;
    cfg.high_cfg = 32'h4444_4444;
    per = '0;
    gpio_out = '0;
    gpio_oe = '0;
    ext = 5'h1F;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    cfg.low_cfg[11:8] <= CFG_ALT_OUT;
    cfg.timer_two_output_enables[12] <= 1'b1;
    per.timer_two_channel_four <= 1'b1;
    tick(4);
    chk({2'b0, pad_oe[0], pad_out[0], pin_in.timer_two_channel_four}, 5'h07);
    chk({4'b0, boot}, 5'h00);
    @(posedge i_clock);
    cfg.tim2_remap[7] <= 1'b1;
    cfg.ser2_mode <= SER_MODE_TWI;
    cfg.low_cfg[11:8] <= CFG_ALT_OD;
    tick(2);
    chk({3'b0, pad_oe[0], pad_out[0]}, 5'h02);
    @(posedge i_clock);
    per.ser2_twi_clk <= 1'b1;
    tick(4);
    chk({2'b0, pad_oe[0], pin[0], pin_in.timer_two_channel_four}, 5'h02);
    @(posedge i_clock);
    cfg.ser2_mode <= SER_MODE_SPI;
    cfg.ser2_spicfg[4] <= 1'b1;
    cfg.low_cfg[11:8] <= CFG_ALT_OUT;
    per.ser2_spi_clk <= 1'b1;
    tick(2);
    chk({3'b0, pad_oe[0], pad_out[0]}, 5'h03);
    @(posedge i_clock);
    cfg.ser2_spicfg[4] <= 1'b0;
    ext <= 5'h1D;
    tick(4);
    chk({2'b0, pad_oe[0], pin_in.ser2_spi_clk, pin_in.ser2_ssel_n}, 5'h02);
    @(posedge i_clock);
    cfg.low_cfg[15:12] <= CFG_ALT_OUT;
    cfg.trace_en <= 1'b1;
    cfg.timer_two_output_enables[4] <= 1'b1;
    per.timer_two_channel_two <= 1'b1;
    tick(4);
    chk({2'b0, pad_oe[1], pad_out[1], pin_in.timer_two_channel_two}, 5'h07);
    @(posedge i_clock);
    cfg.tim2_remap[5] <= 1'b1;
    tick(4);
    chk({2'b0, pad_oe[1], pad_out[1], pin_in.timer_two_channel_two}, 5'h04);
    @(posedge i_clock);
    cfg.high_cfg[7:0] <= {CFG_ANALOG, CFG_ANALOG};
    tick(2);
    chk({1'b0, an4, an5, pad_analog[2], pad_analog[3]}, 5'h0F);
    @(posedge i_clock);
    cfg.high_cfg[7:0] <= {CFG_ALT_OUT, CFG_ALT_OUT};
    cfg.trace_4wire <= 1'b1;
    per.trace_d3 <= 1'b1;
    per.pkt_frame <= 1'b1;
    tick(2);
    chk({an4, pad_oe[3:2], pad_out[3:2]}, 5'h0E);
    @(posedge i_clock);
    cfg.trace_en <= 1'b0;
    tick(2);
    chk({an5, pad_oe[3:2], pad_out[3:2]}, 5'h0D);
    @(posedge i_clock);
    cfg.high_cfg[11:8] <= CFG_ALT_OUT;
    cfg.timer_one_output_enables[8] <= 1'b1;
    per.timer_one_channel_three <= 1'b1;
    tick(4);
    chk({2'b0, pad_oe[4], pad_out[4], pin_in.timer_one_channel_three}, 5'h07);
    @(posedge i_clock);
    cfg.timer_one_output_enables[8] <= 1'b0;
    ext[4] <= 1'b0;
    tick(4);
    chk({2'b0, pad_oe[4], gpio_in[4], pin_in.timer_one_channel_three}, 5'h00);
    @(posedge i_clock);
    cfg.high_cfg[11:8] <= CFG_OUT;
    gpio_oe[4] <= 1'b1;
    gpio_out[4] <= 1'b1;
    tick(4);
    chk({2'b0, pad_oe[4], pad_out[4], gpio_in[4]}, 5'h07);
    @(posedge i_clock);
    cfg.high_cfg[7:4] <= CFG_INPUT;
    // Strap level flips after the window to show the request is held
    for (int v = 0; v < 2; v++) begin
      @(posedge i_clock);
      ext[3] <= v[0];
      i_external_reset_n <= 1'b0;
      tick(4);
      @(posedge i_clock);
      i_external_reset_n <= 1'b1;
      tick(8);
      @(posedge i_clock);
      ext[3] <= ~v[0];
      tick(4);
      chk({4'b0, boot}, {4'b0, ~v[0]});
    end
    results();
  end
endmodule
bind port_a_upper_pin_mux pin_mux_properties u_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
  .i_periph(i_periph), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .o_pad_analog(o_pad_analog),
  .o_analog_input_four(o_analog_input_four));
